// ---- core/sps_pkg.sv ----
package sps_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPS_OFF_STEP = 8'h04;
  localparam logic [7:0] SPS_OFF_STATUS = 8'h08;
  localparam logic [7:0] SPS_OFF_STEPCNT = 8'h0C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SPS_CTRL_SW_SEL = 0;
  localparam int SPS_CTRL_SW_MODE = 1;
  localparam int SPS_CTRL_SW_DIR = 2;
  localparam int SPS_CTRL_EN = 3;
  localparam int SPS_STEP_GO = 0;
  localparam int SPS_ST_POS_LSB = 0;
  localparam int SPS_ST_OUT_LSB = 4;
  localparam int SPS_ST_CLEAR = 8;
  localparam int SPS_ST_MODE = 9;
  localparam int SPS_ST_DIR = 10;
  localparam int SPS_ST_EN = 11;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] SPS_CTRL_RST = 4'h8;
  localparam logic [2:0] SPS_POS_RST = 3'h0;
  localparam logic [31:0] SPS_STEPCNT_RST = 32'h00000000;

  // AXI responses
  localparam logic [1:0] SPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SPS_CLK_PERIOD_NS = 25;
  localparam int SPS_MODE_DIR_HOLD_NS = 4000;
  localparam int SPS_RESET_MIN_NS = 10000;
  localparam int SPS_MODE_DIR_HOLD_CYC =
    (SPS_MODE_DIR_HOLD_NS + SPS_CLK_PERIOD_NS - 1) / SPS_CLK_PERIOD_NS;
  localparam int SPS_RESET_MIN_CYC =
    (SPS_RESET_MIN_NS + SPS_CLK_PERIOD_NS - 1) / SPS_CLK_PERIOD_NS;

  // Phase winding order in output vectors: {bb, b, ab, a}
  typedef enum logic [2:0] {
    SPS_POS_A_BB = 3'b000,
    SPS_POS_A = 3'b001,
    SPS_POS_A_B = 3'b010,
    SPS_POS_B = 3'b011,
    SPS_POS_B_AB = 3'b100,
    SPS_POS_AB = 3'b101,
    SPS_POS_AB_BB = 3'b110,
    SPS_POS_BB = 3'b111
  } sps_pos_t;

endpackage

// ---- core/sps_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module sps_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_rst_val,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_width_chk
    $error("sps_sync: WIDTH must be at least 1");
  end

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= i_rst_val;
      o_sync <= i_rst_val;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- core/sps_top.sv ----
// Contract
// - Advance only on step rising edge; with SPS_CTRL_SW_SEL set, a STEP register write with GO set advances instead
// - Mode low full step, high half step
// - Direction low forward, high reverse
// - Clear low resets position, outputs off
// - Enable low forces all outputs off
// - Position keeps advancing while outputs disabled
// - After clear, drive phase A and BB
// - Mode change continues from current position
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sps_top
  import sps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Motor control pins
  input wire logic i_step,
  input wire logic i_excitation_mode,
  input wire logic i_rotation_direction_select,
  input wire logic i_sequencer_clear_low_n,
  input wire logic i_output_enable,
  // Winding drives
  output logic o_phase_a,
  output logic o_phase_ab,
  output logic o_phase_b,
  output logic o_phase_bb,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Next position; full step lands on pair states (even codes)
  function automatic logic [2:0] sps_next_pos(input logic [2:0] pos,
                                              input logic half,
                                              input logic rev);
    logic [2:0] delta;
    delta = (half || pos[0]) ? 3'h1 : 3'h2;
    if (rev) begin
      sps_next_pos = pos - delta;
    end else begin
      sps_next_pos = pos + delta;
    end
  endfunction

  // Winding pattern {bb, b, ab, a} for a position
  function automatic logic [3:0] sps_pattern(input logic [2:0] pos);
    logic [3:0] pat;
    pat = 4'h0;
    case (pos)
      SPS_POS_A_BB: pat = 4'h9;
      SPS_POS_A: pat = 4'h1;
      SPS_POS_A_B: pat = 4'h5;
      SPS_POS_B: pat = 4'h4;
      SPS_POS_B_AB: pat = 4'h6;
      SPS_POS_AB: pat = 4'h2;
      SPS_POS_AB_BB: pat = 4'hA;
      default: pat = 4'h8;
    endcase
    sps_pattern = pat;
  endfunction

  function automatic logic sps_addr_is(input logic [7:0] addr,
                                       input logic [7:0] off);
    sps_addr_is = (addr[7:2] == off[7:2]);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [4:0] pins_sync;
  logic step_s;
  logic mode_s;
  logic dir_s;
  logic clear_n_s;
  logic enable_s;

  sps_sync #(
    .WIDTH(5)
  ) sps_sync_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_output_enable, i_sequencer_clear_low_n,
              i_rotation_direction_select, i_excitation_mode, i_step}),
    .i_rst_val(5'h00),
    .o_sync(pins_sync)
  );

  assign step_s = pins_sync[0];
  assign mode_s = pins_sync[1];
  assign dir_s = pins_sync[2];
  assign clear_n_s = pins_sync[3];
  assign enable_s = pins_sync[4];

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic sw_step_r;
  logic step_d_r;
  logic [2:0] pos_r;
  logic [31:0] stepcnt_r;
  logic [7:0] aw_addr_r;
  logic wr_fire;
  logic [3:0] drive_r;
  logic step_rise;
  logic step_evt;
  logic mode_eff;
  logic dir_eff;
  logic enable_eff;

  // Rising edge only; falling edges are dropped
  assign step_rise = step_s && !step_d_r;
  assign step_evt = ctrl_r[SPS_CTRL_SW_SEL] ? sw_step_r : step_rise;
  assign mode_eff = ctrl_r[SPS_CTRL_SW_SEL] ? ctrl_r[SPS_CTRL_SW_MODE] : mode_s;
  assign dir_eff = ctrl_r[SPS_CTRL_SW_SEL] ? ctrl_r[SPS_CTRL_SW_DIR] : dir_s;
  assign enable_eff = enable_s && ctrl_r[SPS_CTRL_EN];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_s;
    end
  end

  // ---------------------------------------------------------------
  // Phase position
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pos_r <= SPS_POS_RST;
    end else if (!clear_n_s) begin
      pos_r <= SPS_POS_RST;
    end else if (step_evt) begin
      // Advances regardless of enable; mode read fresh each step
      pos_r <= sps_next_pos(pos_r, mode_eff, dir_eff);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stepcnt_r <= SPS_STEPCNT_RST;
    end else if (wr_fire && sps_addr_is(aw_addr_r, SPS_OFF_STEPCNT)) begin
      stepcnt_r <= SPS_STEPCNT_RST;
    end else if (clear_n_s && step_evt) begin
      stepcnt_r <= stepcnt_r + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // Winding drive
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      drive_r <= 4'h0;
    end else if (!clear_n_s) begin
      drive_r <= 4'h0;
    end else if (!enable_eff) begin
      drive_r <= 4'h0;
    end else begin
      drive_r <= sps_pattern(pos_r);
    end
  end

  assign o_phase_a = drive_r[0];
  assign o_phase_ab = drive_r[1];
  assign o_phase_b = drive_r[2];
  assign o_phase_bb = drive_r[3];

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_hit;

  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_hit = sps_addr_is(aw_addr_r, SPS_OFF_CTRL) ||
                  sps_addr_is(aw_addr_r, SPS_OFF_STEP) ||
                  sps_addr_is(aw_addr_r, SPS_OFF_STEPCNT);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      awready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b1;
      aw_addr_r <= i_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end else if (bvalid_r && i_bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wready_r <= 1'b1;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (i_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b1;
      w_data_r <= i_wdata;
      w_strb_r <= i_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end else if (bvalid_r && i_bready) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= SPS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
    end else if (bvalid_r && i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= SPS_CTRL_RST;
    end else if (wr_fire && sps_addr_is(aw_addr_r, SPS_OFF_CTRL) && w_strb_r[0]) begin
      ctrl_r <= w_data_r[3:0];
    end
  end

  // Software step is a one-cycle pulse
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_step_r <= 1'b0;
    end else begin
      sw_step_r <= wr_fire && sps_addr_is(aw_addr_r, SPS_OFF_STEP) &&
                   w_strb_r[0] && w_data_r[SPS_STEP_GO];
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic [1:0] rd_resp;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_resp = SPS_RESP_OKAY;
    if (sps_addr_is(i_araddr, SPS_OFF_CTRL)) begin
      rd_mux[3:0] = ctrl_r;
    end else if (sps_addr_is(i_araddr, SPS_OFF_STEP)) begin
      rd_mux = 32'h00000000;
    end else if (sps_addr_is(i_araddr, SPS_OFF_STATUS)) begin
      rd_mux[SPS_ST_POS_LSB +: 3] = pos_r;
      rd_mux[SPS_ST_OUT_LSB +: 4] = drive_r;
      rd_mux[SPS_ST_CLEAR] = !clear_n_s;
      rd_mux[SPS_ST_MODE] = mode_eff;
      rd_mux[SPS_ST_DIR] = dir_eff;
      rd_mux[SPS_ST_EN] = enable_eff;
    end else if (sps_addr_is(i_araddr, SPS_OFF_STEPCNT)) begin
      rd_mux = stepcnt_r;
    end else begin
      rd_resp = SPS_RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= SPS_RESP_OKAY;
    end else if (i_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_resp;
    end else if (rvalid_r && i_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

endmodule

`default_nettype wire

// ---- tb/sps_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module sps_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_sequencer_clear_low_n,
  input wire logic i_output_enable,
  input wire logic o_phase_a,
  input wire logic o_phase_ab,
  input wire logic o_phase_b,
  input wire logic o_phase_bb,
  input wire logic o_awready,
  input wire logic o_bvalid,
  input wire logic i_bready
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire logic clr_n = i_sequencer_clear_low_n;
  wire logic en = i_output_enable;
  wire logic [3:0] ph = {o_phase_bb, o_phase_b, o_phase_ab, o_phase_a};
  logic [3:0] quiet_r;

  // ----
  // Cycles since anything that may move the outputs
  // ----
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || $rose(i_step) || $changed(clr_n) || $changed(en) || o_bvalid) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  sequence clr_release;
    $rose(clr_n) ##1 (clr_n && en && !i_step) [*4];
  endsequence
  sequence en_return;
    $rose(en) ##1 (en && clr_n) [*4];
  endsequence

  chk_no_cause: assert property (!$stable(ph) |-> quiet_r <= 4'h6)
    else $error("outputs moved without a cause");
  chk_step_moves: assert property ($rose(i_step) && clr_n && en |-> ##[1:5] $changed(ph))
    else $error("step did not move outputs");
  chk_clear_off: assert property (!clr_n [*3] |=> ph == 4'h0)
    else $error("outputs on during clear");
  chk_rst_off: assert property ($rose(i_rst_n) |-> ph == 4'h0)
    else $error("outputs on during reset");
  chk_en_off: assert property (!en [*3] |=> ph == 4'h0)
    else $error("outputs on while disabled");
  chk_en_resume: assert property (en_return |-> ph != 4'h0)
    else $error("outputs not resumed");
  chk_init_pair: assert property (clr_release |-> ph == 4'h9)
    else $error("wrong state after clear");
  chk_no_opposed: assert property (!(o_phase_a && o_phase_ab) && !(o_phase_b && o_phase_bb))
    else $error("opposed windings both on");
  chk_aw_blocked: assert property (o_bvalid |-> !o_awready)
    else $error("address taken during response");
  chk_b_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("response repeated");
endmodule

bind sps_top sps_props sps_props_inst (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_step(i_step),
  .i_sequencer_clear_low_n(i_sequencer_clear_low_n),
  .i_output_enable(i_output_enable),
  .o_phase_a(o_phase_a),
  .o_phase_ab(o_phase_ab),
  .o_phase_b(o_phase_b),
  .o_phase_bb(o_phase_bb),
  .o_awready(o_awready),
  .o_bvalid(o_bvalid),
  .i_bready(i_bready)
);

`default_nettype wire

// ---- tb/sps_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module sps_host
  import sps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_mode,
  input wire logic i_dir,
  input wire logic i_clr_n,
  input wire logic i_en,
  output logic o_busy,
  output logic o_step,
  output logic o_mode,
  output logic o_dir,
  output logic o_clr_n,
  output logic o_en
);
  localparam int PW = 400;
  int cnt_r;
  int pwr_r;

  assign o_busy = cnt_r != 0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_r <= SPS_RESET_MIN_CYC;
      o_clr_n <= 1'b0;
      o_en <= 1'b1;
    end else begin
      if (pwr_r > 0) begin
        pwr_r <= pwr_r - 1;
      end
      o_clr_n <= i_clr_n && (pwr_r == 0);
      o_en <= i_en;
    end
  end

  // ----
  // Levels settle 200 cycles before the rise and hold past it
  // ----
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= 0;
      o_step <= 1'b0;
      o_mode <= 1'b0;
      o_dir <= 1'b0;
    end else begin
      o_step <= (cnt_r > PW / 2) && (cnt_r <= PW + PW / 2);
      if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end else if (i_req) begin
        o_mode <= i_mode;
        o_dir <= i_dir;
        cnt_r <= 2 * PW;
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/test_stepper_phase_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_stepper_phase_sequencer
  import sps_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic mode = 1'b0;
  logic dir = 1'b0;
  logic clr_n = 1'b1;
  logic en = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  wire logic step, pmode, pdir, pclr_n, pen, busy, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] ph;
  int fails = 0;
  int samples_checked = 0;
  logic [2:0] pos = 3'h0;
  logic [7:0] seed = 8'h3D;
  logic m, v;
  logic [31:0] d;
  logic [1:0] r;

  always #12.5 clk = ~clk;

  sps_host sps_host_inst (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_mode(mode),
    .i_dir(dir), .i_clr_n(clr_n), .i_en(en), .o_busy(busy), .o_step(step), .o_mode(pmode),
    .o_dir(pdir), .o_clr_n(pclr_n), .o_en(pen));

  sps_top sps_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_step(step), .i_excitation_mode(pmode),
    .i_rotation_direction_select(pdir), .i_sequencer_clear_low_n(pclr_n),
    .i_output_enable(pen), .o_phase_a(ph[0]), .o_phase_ab(ph[1]), .o_phase_b(ph[2]),
    .o_phase_bb(ph[3]), .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));

  // Winding pattern {bb, b, ab, a} for each position
  function automatic logic [3:0] pat(input logic [2:0] p);
    return 4'(32'h8A264519 >> {p, 2'b00});
  endfunction

  function automatic logic [2:0] nxt(input logic [2:0] p, input logic h, input logic rv);
    logic [2:0] k;
    k = (h || p[0]) ? 3'h1 : 3'h2;
    return rv ? p - k : p + k;
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input int n);
    if (n >= 2000) begin
      fails++;
      final_report;
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    int n;
    awaddr <= a;
    wdata <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      n++;
    end while (!bvalid && n < 2000);
    r = bresp;
    timeout(n);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    araddr <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
      n++;
    end while (!rvalid && n < 2000);
    d = rdata;
    r = rresp;
    timeout(n);
  endtask

  task automatic pulse(input logic h, input logic rv);
    int n;
    req <= 1'b1;
    mode <= h;
    dir <= rv;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 2000);
    timeout(n);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    axr(SPS_OFF_CTRL);
    `CHK(d[3:0], SPS_CTRL_RST)
    axr(8'h10);
    `CHK({r, d}, {SPS_RESP_SLVERR, 32'h0})
    axw(8'h10, 32'hF);
    `CHK(r, SPS_RESP_SLVERR)
    repeat (500) @(posedge clk);
    `CHK(ph, 4'h9)
    clr_n <= 1'b0;
    pulse(1'b1, 1'b0);
    clr_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(ph, 4'h9)
    axw(SPS_OFF_STEPCNT, 32'h0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      m = (i == 0) || (seed[0] && i > 1);
      v = seed[1] && i > 1;
      en <= !(i inside {[8:10]});
      pulse(m, v);
      pos = nxt(pos, m, v);
      `CHK(ph, en ? pat(pos) : 4'h0)
    end
    axr(SPS_OFF_STEPCNT);
    `CHK(d, 32'h18)
    axr(SPS_OFF_STATUS);
    `CHK({d[11:4], d[2:0]}, {1'b1, v, m, 1'b0, pat(pos), pos})
    axw(SPS_OFF_CTRL, 32'hF);
    axw(SPS_OFF_STEP, 32'h1);
    repeat (8) @(posedge clk);
    pos = nxt(pos, 1'b1, 1'b1);
    `CHK(ph, pat(pos))
    axw(SPS_OFF_CTRL, 32'h8);
    final_report;
  end
endmodule

`default_nettype wire
